// ---- peak_status_pkg.sv ----
// Shared constants and types for the peak and status register bank
package peak_status_pkg;

    // ------------------------------------------------------------
    // Register addresses on the serial register port
    // ------------------------------------------------------------
    localparam logic [15:0] CURRENT_PEAK_ADDR = 16'he500;  // Current peak word
    localparam logic [15:0] VOLTAGE_PEAK_ADDR = 16'he501;  // Voltage peak word
    localparam logic [15:0] STATUS_FIRST_ADDR = 16'he502;  // First status word
    localparam logic [15:0] RESERVED_LO_ADDR  = 16'hea0b;  // Reserved span start
    localparam logic [15:0] RESERVED_HI_ADDR  = 16'hebfe;  // Reserved span end
    localparam logic [15:0] PORT_SELECT_ADDR  = 16'hebff;  // Chip-select pin control
    localparam logic [15:0] LP_OC_LEVEL_ADDR  = 16'hec00;  // Overcurrent level
    localparam logic [15:0] LP_CONFIG_ADDR    = 16'hec01;  // Reduced-power config

    // ------------------------------------------------------------
    // Field layout of the peak words
    // ------------------------------------------------------------
    localparam int MAG_W     = 24;  // Magnitude width, bits 23:0
    localparam int SRC_W     = 3;   // Phase source flags, bits 26:24
    localparam int PEAK_PAD  = 5;   // Bits 31:27, always zero

    // ------------------------------------------------------------
    // Field layout of the first status word
    // ------------------------------------------------------------
    localparam int ST_TOTAL_ACTIVE   = 0;  // Total active half full
    localparam int ST_FUND_ACTIVE    = 1;  // Fundamental active half full
    localparam int ST_RESERVED       = 2;  // Always zero
    localparam int ST_FUND_REACTIVE  = 3;  // Fundamental reactive half full
    localparam int ST_APPARENT       = 4;  // Apparent half full
    localparam int ST_LINE_CYCLE     = 5;  // Line-cycle accumulation done
    localparam int ST_REV_A          = 6;  // Phase A reversal, B and C follow
    localparam int STATUS_W          = 9;  // Implemented status bits
    localparam int PHASES            = 3;  // Phases A, B, C
    localparam logic [STATUS_W-1:0] STATUS_RESET = 9'h000;

    // ------------------------------------------------------------
    // Reset values of the writable registers
    // ------------------------------------------------------------
    localparam int          BYTE_W       = 8;
    localparam logic [7:0]  LP_OC_RESET  = 8'h07;
    localparam logic [7:0]  LP_CFG_RESET = 8'h00;

    // ------------------------------------------------------------
    // Transmitted word classes, one-hot
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        CLS_ZP24   = 5'h01,  // 24-bit, 8 zero MSBs
        CLS_ZP20   = 5'h02,  // 20-bit, 12 zero MSBs
        CLS_SE24   = 5'h04,  // 24-bit signed, sign extended
        CLS_ZP10   = 5'h08,  // 10-bit in 16-bit word
        CLS_FULL32 = 5'h10   // Sent as stored
    } word_class_t;

endpackage : peak_status_pkg

// ---- word_formatter.sv ----
// Read-word formatter: pads or sign-extends a register value, registered out
`timescale 1ns/1ps
`default_nettype none

module word_formatter (
    input  wire logic                       clock_i,
    input  wire logic                       sys_rst_i,
    input  wire logic                       load_i,
    input  wire peak_status_pkg::word_class_t word_class_i,
    input  wire logic [31:0]                raw_i,
    output logic      [31:0]                word_o,
    output logic                            valid_o
);
    import peak_status_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] word_reg;   // Formatted word
    logic [31:0] word_next;
    logic        valid_reg;  // One-cycle answer marker
    logic        valid_next;

    // ------------------------------------------------------------
    // Next-value logic
    // ------------------------------------------------------------
    // Word held between reads so the host sees a stable value
    always_comb begin
        word_next  = word_reg;
        valid_next = load_i;
        if (load_i) begin
            case (word_class_i)
                CLS_ZP24:   word_next = {8'h00, raw_i[23:0]};
                CLS_ZP20:   word_next = {12'h000, raw_i[19:0]};
                CLS_SE24:   word_next = {{8{raw_i[23]}}, raw_i[23:0]};
                CLS_ZP10:   word_next = {16'h0000, 6'h00, raw_i[9:0]};
                CLS_FULL32: word_next = raw_i;
                default:    word_next = 32'h0000_0000;
            endcase
        end
    end

    // Registers only
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            word_reg  <= 32'h0000_0000;
            valid_reg <= 1'b0;
        end else begin
            word_reg  <= word_next;
            valid_reg <= valid_next;
        end
    end

    assign word_o  = word_reg;
    assign valid_o = valid_reg;

endmodule : word_formatter

`default_nettype wire

// ---- peak_detect_and_status_flags.sv ----
// Peak registers, first status word and low-power configuration registers
`timescale 1ns/1ps
`default_nettype none

module peak_detect_and_status_flags (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // Register access from the serial port
    input  wire logic [15:0] reg_addr_i,
    input  wire logic        reg_read_i,
    input  wire logic        reg_write_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    // Port selection pin control
    input  wire logic        spi_active_i,
    output logic             secondary_port_select_o,
    // Peak detector results
    input  wire logic        current_peak_valid_i,
    input  wire logic [23:0] current_peak_magnitude_i,
    input  wire logic [2:0]  current_peak_source_i,
    input  wire logic        voltage_peak_valid_i,
    input  wire logic [23:0] voltage_peak_magnitude_i,
    input  wire logic [2:0]  voltage_peak_source_i,
    // Bit 30 of each phase energy accumulator
    input  wire logic [2:0]  total_active_bit30_i,
    input  wire logic [2:0]  fund_active_bit30_i,
    input  wire logic [2:0]  fund_reactive_bit30_i,
    input  wire logic [2:0]  apparent_bit30_i,
    // Line-cycle accumulation
    input  wire logic        line_cycle_mode_i,
    input  wire logic        line_cycle_done_i,
    // Active power signs, one bit per phase, 1 = negative
    input  wire logic        reversal_source_select_i,
    input  wire logic [2:0]  total_power_sign_i,
    input  wire logic [2:0]  fund_power_sign_i,
    output logic      [2:0]  power_sign_flags_o,
    // Low-power configuration
    output logic      [7:0]  low_power_overcurrent_level_o,
    output logic      [7:0]  low_power_config_o
);
    import peak_status_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Write to a given address, used for every writable register
    function automatic logic wr_hit(input logic [15:0] addr,
                                    input logic        wr,
                                    input logic [15:0] target);
        wr_hit = wr && (addr == target);
    endfunction : wr_hit

    // Any accumulator bit 30 that moved since last cycle
    function automatic logic moved(input logic [2:0] cur,
                                   input logic [2:0] prev);
        moved = |(cur ^ prev);
    endfunction : moved

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [MAG_W-1:0]    cur_mag_reg;      // Current peak magnitude
    logic [MAG_W-1:0]    cur_mag_next;
    logic [SRC_W-1:0]    cur_src_reg;      // Current peak phase flags
    logic [SRC_W-1:0]    cur_src_next;
    logic [MAG_W-1:0]    volt_mag_reg;     // Voltage peak magnitude
    logic [MAG_W-1:0]    volt_mag_next;
    logic [SRC_W-1:0]    volt_src_reg;     // Voltage peak phase flags
    logic [SRC_W-1:0]    volt_src_next;
    logic [STATUS_W-1:0] status_reg;       // Sticky event flags
    logic [STATUS_W-1:0] status_next;
    logic [STATUS_W-1:0] status_set;       // Events this cycle
    logic [STATUS_W-1:0] status_clr;       // Host clear mask
    logic [2:0]          sign_reg;         // Last seen power sign
    logic [2:0]          sign_next;
    logic [2:0]          sign_sel;         // Sign of chosen power path
    logic [11:0]         bit30_reg;        // Previous accumulator bits
    logic [11:0]         bit30_next;
    logic [7:0]          lp_oc_reg;        // Overcurrent level
    logic [7:0]          lp_oc_next;
    logic [7:0]          lp_cfg_reg;       // Reduced-power config
    logic [7:0]          lp_cfg_next;
    logic                port_sel_reg;     // Select pin level
    logic                port_sel_next;
    logic [31:0]         rd_raw;           // Unformatted read value
    word_class_t         rd_class;         // Class of addressed word

    // ------------------------------------------------------------
    // Peak registers
    // ------------------------------------------------------------
    // Detector presents a new peak with a valid strobe; hold otherwise
    always_comb begin
        cur_mag_next  = cur_mag_reg;
        cur_src_next  = cur_src_reg;
        volt_mag_next = volt_mag_reg;
        volt_src_next = volt_src_reg;
        if (current_peak_valid_i) begin
            cur_mag_next = current_peak_magnitude_i;
            cur_src_next = current_peak_source_i;
        end
        if (voltage_peak_valid_i) begin
            volt_mag_next = voltage_peak_magnitude_i;
            volt_src_next = voltage_peak_source_i;
        end
    end

    // Peaks clear only on reset; host writes do not touch them
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cur_mag_reg  <= 24'h000000;
            cur_src_reg  <= 3'h0;
            volt_mag_reg <= 24'h000000;
            volt_src_reg <= 3'h0;
        end else begin
            cur_mag_reg  <= cur_mag_next;
            cur_src_reg  <= cur_src_next;
            volt_mag_reg <= volt_mag_next;
            volt_src_reg <= volt_src_next;
        end
    end

    // ------------------------------------------------------------
    // Event detection and sticky status
    // ------------------------------------------------------------
    // Accumulator bit 30 history and sign history
    always_comb begin
        bit30_next = {apparent_bit30_i, fund_reactive_bit30_i,
                      fund_active_bit30_i, total_active_bit30_i};
        sign_sel   = reversal_source_select_i ? fund_power_sign_i
                                              : total_power_sign_i;
        sign_next  = sign_sel;
    end

    // One set term per flag
    always_comb begin
        status_set = '0;
        status_set[ST_TOTAL_ACTIVE] = moved(total_active_bit30_i,
                                            bit30_reg[2:0]);
        status_set[ST_FUND_ACTIVE] = moved(fund_active_bit30_i,
                                           bit30_reg[5:3]);
        status_set[ST_FUND_REACTIVE] = moved(fund_reactive_bit30_i,
                                             bit30_reg[8:6]);
        status_set[ST_APPARENT] = moved(apparent_bit30_i,
                                        bit30_reg[11:9]);
        status_set[ST_LINE_CYCLE] = line_cycle_mode_i && line_cycle_done_i;
        status_set[ST_REV_A+:PHASES] = sign_sel ^ sign_reg;
    end

    // Clear-on-one write, then set; set wins so no event is lost
    always_comb begin
        status_clr = '0;
        if (wr_hit(reg_addr_i, reg_write_i, STATUS_FIRST_ADDR)) begin
            status_clr = reg_wdata_i[STATUS_W-1:0];
        end
        status_next = (status_reg & ~status_clr) | status_set;
        status_next[ST_RESERVED] = 1'b0;
    end

    // Histories start at zero, so a high input after reset flags once
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            status_reg <= STATUS_RESET;
            bit30_reg  <= 12'h000;
            sign_reg   <= 3'h0;
        end else begin
            status_reg <= status_next;
            bit30_reg  <= bit30_next;
            sign_reg   <= sign_next;
        end
    end

    // ------------------------------------------------------------
    // Writable configuration and pin control
    // ------------------------------------------------------------
    always_comb begin
        lp_oc_next    = lp_oc_reg;
        lp_cfg_next   = lp_cfg_reg;
        port_sel_next = port_sel_reg;
        if (wr_hit(reg_addr_i, reg_write_i, LP_OC_LEVEL_ADDR)) begin
            lp_oc_next = reg_wdata_i[BYTE_W-1:0];
        end
        if (wr_hit(reg_addr_i, reg_write_i, LP_CONFIG_ADDR)) begin
            lp_cfg_next = reg_wdata_i[BYTE_W-1:0];
        end
        // pin takes a write only while SPI active; held otherwise
        if (wr_hit(reg_addr_i, reg_write_i, PORT_SELECT_ADDR) && spi_active_i) begin
            port_sel_next = reg_wdata_i[0];
        end
    end

    // Reset values feed the low-power logic before any host write
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            lp_oc_reg    <= LP_OC_RESET;
            lp_cfg_reg   <= LP_CFG_RESET;
            port_sel_reg <= 1'b0;
        end else begin
            lp_oc_reg    <= lp_oc_next;
            lp_cfg_reg   <= lp_cfg_next;
            port_sel_reg <= port_sel_next;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Unmapped addresses answer zero rather than stale data
    always_comb begin
        rd_raw   = 32'h0000_0000;
        rd_class = CLS_FULL32;
        case (reg_addr_i)
            CURRENT_PEAK_ADDR: begin
                rd_raw = {{PEAK_PAD{1'b0}}, cur_src_reg, cur_mag_reg};
            end
            VOLTAGE_PEAK_ADDR: begin
                rd_raw = {{PEAK_PAD{1'b0}}, volt_src_reg, volt_mag_reg};
            end
            STATUS_FIRST_ADDR: begin
                rd_raw = {23'h000000, status_reg};
            end
            LP_OC_LEVEL_ADDR: begin
                rd_raw = {24'h000000, lp_oc_reg};
            end
            LP_CONFIG_ADDR: begin
                rd_raw = {24'h000000, lp_cfg_reg};
            end
            default: begin
                rd_raw = 32'h0000_0000;
            end
        endcase
    end

    word_formatter u_word_formatter (
        .clock_i      (clock_i),
        .sys_rst_i    (sys_rst_i),
        .load_i       (reg_read_i),
        .word_class_i (rd_class),
        .raw_i        (rd_raw),
        .word_o       (reg_rdata_o),
        .valid_o      (reg_rvalid_o)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign secondary_port_select_o       = port_sel_reg;
    assign power_sign_flags_o            = sign_reg;
    assign low_power_overcurrent_level_o = lp_oc_reg;
    assign low_power_config_o            = lp_cfg_reg;

endmodule : peak_detect_and_status_flags

`default_nettype wire

// ---- peak_status_properties.sv ----
// Port checker for the peak and status register bank, with its bind
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Checker module
// ------------------------------------------------------------
module peak_status_properties
    import peak_status_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic        reg_read_i,
    input wire logic        reg_write_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic        spi_active_i,
    input wire logic        secondary_port_select_o,
    input wire logic        reversal_source_select_i,
    input wire logic [2:0]  total_power_sign_i,
    input wire logic [2:0]  fund_power_sign_i,
    input wire logic [2:0]  power_sign_flags_o,
    input wire logic [7:0]  low_power_overcurrent_level_o,
    input wire logic [7:0]  low_power_config_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    logic       rd_res;    // Read inside the reserved span
    logic       sel_wr;    // Write that may move the select pin
    logic [2:0] sel_sign;  // Sign source picked by the selector
    assign rd_res   = reg_read_i && reg_addr_i >= RESERVED_LO_ADDR
                      && reg_addr_i <= RESERVED_HI_ADDR;
    assign sel_wr   = reg_write_i && spi_active_i && reg_addr_i == PORT_SELECT_ADDR;
    assign sel_sign = reversal_source_select_i ? fund_power_sign_i : total_power_sign_i;

    read_answer_a: assert property (
        reg_rvalid_o == $past(reg_read_i)) else $error("Read answer pulse misplaced");
    reserved_zero_a: assert property (
        rd_res |=> reg_rdata_o == 32'h0) else $error("Reserved read not zero");
    select_write_a: assert property (
        sel_wr |=> secondary_port_select_o == $past(reg_wdata_i[0]))
        else $error("Select pin missed write");
    select_hold_a: assert property (
        !sel_wr |=> $stable(secondary_port_select_o)) else $error("Select pin moved unasked");
    level_reset_a: assert property (
        $past(sys_rst_i) |-> low_power_overcurrent_level_o == 8'h07 && low_power_config_o == 8'h00)
        else $error("Low-power register reset value wrong");
    oc_write_a: assert property (
        reg_write_i && reg_addr_i == LP_OC_LEVEL_ADDR ##1 1'b1 |-> low_power_overcurrent_level_o ==
        $past(reg_wdata_i[7:0])) else $error("Overcurrent level missed write");
    config_write_a: assert property (
        reg_write_i && reg_addr_i == LP_CONFIG_ADDR
        |=> low_power_config_o == $past(reg_wdata_i[7:0]))
        else $error("Config register missed write");
    peak_pad_a: assert property (
        reg_read_i && (reg_addr_i == CURRENT_PEAK_ADDR || reg_addr_i == VOLTAGE_PEAK_ADDR)
        |=> reg_rdata_o[31:27] == 5'h0) else $error("Peak pad bits not zero");
    status_spare_a: assert property (
        reg_read_i && reg_addr_i == STATUS_FIRST_ADDR |=> reg_rdata_o[2] == 1'b0 &&
        reg_rdata_o[31:9] == 23'h0) else $error("Status spare bits not zero");
    sign_track_a: assert property (
        !$past(sys_rst_i) |-> power_sign_flags_o == $past(sel_sign))
        else $error("Sign flags stale");

    cover property (reg_read_i && reg_addr_i == STATUS_FIRST_ADDR ##1 reg_rdata_o[8:6] != 3'h0);
    cover property (rd_res);
    cover property (sel_wr ##1 secondary_port_select_o);
endmodule : peak_status_properties

bind peak_detect_and_status_flags peak_status_properties u_props (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_read_i(reg_read_i), .reg_write_i(reg_write_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .spi_active_i(spi_active_i),
    .secondary_port_select_o(secondary_port_select_o),
    .reversal_source_select_i(reversal_source_select_i),
    .total_power_sign_i(total_power_sign_i), .fund_power_sign_i(fund_power_sign_i),
    .power_sign_flags_o(power_sign_flags_o),
    .low_power_overcurrent_level_o(low_power_overcurrent_level_o),
    .low_power_config_o(low_power_config_o));
`default_nettype wire

// ---- host_port_model.sv ----
// Host-side model of the register port
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Host model
// ------------------------------------------------------------
module host_port_model (
    input  wire logic        clock_i,
    output logic      [15:0] reg_addr_o,
    output logic             reg_read_o,
    output logic             reg_write_o,
    output logic      [31:0] reg_wdata_o
);
    initial begin
        reg_addr_o  = 16'h0;
        reg_read_o  = 1'b0;
        reg_write_o = 1'b0;
        reg_wdata_o = 32'h0;
    end

    // select address, plain words, write-one clears
    // One request a cycle; idle cycles scramble address and data
    task automatic op(input logic r, input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_read_o  <= r;
        reg_write_o <= w;
        reg_addr_o  <= (r | w) ? a : ~reg_addr_o;
        reg_wdata_o <= w ? d : ~reg_wdata_o;
    endtask : op
endmodule : host_port_model
`default_nettype wire

// ---- test_peak_detect_and_status_flags.sv ----
// Self-checking bench for the peak and status register bank
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module test_peak_detect_and_status_flags;
    import peak_status_pkg::*;
    typedef struct {int cpk, vpk, st, oc, cfg, sel, sgn, rd, rv, ta, fa, fr, ap;} model_t;
    logic        clock_i = 1'b0, sys_rst_i = 1'b1;  // Clock and reset
    logic [15:0] reg_addr, a;                       // Host address, next pick
    logic        reg_read, reg_write, reg_rvalid, sel_pin;
    logic [31:0] reg_wdata, reg_rdata, e, f, g;     // Port data, random words
    logic        spi = 1'b0, ipk_v = 1'b0, vpk_v = 1'b0, rev_sel = 1'b0;
    logic        lc_mode = 1'b0, lc_done = 1'b0;    // Line-cycle controls
    logic [23:0] ipk_m = '0, vpk_m = '0;            // Peak magnitudes
    logic [2:0]  ipk_s = '0, vpk_s = '0, ta = '0, fa = '0, fr = '0, ap = '0, ts = '0, fs = '0;
    logic [2:0]  signs;                             // Sign flags seen
    logic [7:0]  oc_lvl, cfg;                       // Low-power outputs
    int          failures = 0, n_tests = 0;         // Verdict counters
    model_t      m;                                 // Reference state
    logic [15:0] tab [8] = '{CURRENT_PEAK_ADDR, VOLTAGE_PEAK_ADDR, STATUS_FIRST_ADDR,
        RESERVED_LO_ADDR, RESERVED_HI_ADDR, PORT_SELECT_ADDR, LP_OC_LEVEL_ADDR, LP_CONFIG_ADDR};

    // 25 ns period
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    peak_detect_and_status_flags dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr), .reg_read_i(reg_read),
        .reg_write_i(reg_write), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .reg_rvalid_o(reg_rvalid), .spi_active_i(spi), .secondary_port_select_o(sel_pin),
        .current_peak_valid_i(ipk_v), .current_peak_magnitude_i(ipk_m),
        .current_peak_source_i(ipk_s), .voltage_peak_valid_i(vpk_v),
        .voltage_peak_magnitude_i(vpk_m), .voltage_peak_source_i(vpk_s),
        .total_active_bit30_i(ta), .fund_active_bit30_i(fa), .fund_reactive_bit30_i(fr),
        .apparent_bit30_i(ap), .line_cycle_mode_i(lc_mode), .line_cycle_done_i(lc_done),
        .reversal_source_select_i(rev_sel), .total_power_sign_i(ts), .fund_power_sign_i(fs),
        .power_sign_flags_o(signs), .low_power_overcurrent_level_o(oc_lvl),
        .low_power_config_o(cfg));

    host_port_model host (
        .clock_i(clock_i), .reg_addr_o(reg_addr), .reg_read_o(reg_read),
        .reg_write_o(reg_write), .reg_wdata_o(reg_wdata));

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic int rd_val(input logic [15:0] ad);
        case (ad)
            CURRENT_PEAK_ADDR: return m.cpk;
            VOLTAGE_PEAK_ADDR: return m.vpk;
            STATUS_FIRST_ADDR: return m.st;
            LP_OC_LEVEL_ADDR:  return m.oc;
            LP_CONFIG_ADDR:    return m.cfg;
            default:           return 0;
        endcase
    endfunction : rd_val

    // Mirrors the design edge by edge; reads see pre-write state
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            m = '{0, 0, 0, 7, 0, 0, 0, 0, 0, 0, 0, 0, 0};
        end else begin
            m.rv = reg_read;
            if (reg_read) m.rd = rd_val(reg_addr);
            if (reg_write && reg_addr == STATUS_FIRST_ADDR) m.st = m.st & ~int'(reg_wdata[8:0]);
            if (ta != m.ta) m.st = m.st | 1;
            if (fa != m.fa) m.st = m.st | 2;
            if (fr != m.fr) m.st = m.st | 8;
            if (ap != m.ap) m.st = m.st | 16;
            if (lc_mode && lc_done) m.st = m.st | 32;
            m.st = m.st | (((rev_sel ? fs : ts) ^ m.sgn) << 6);
            m.sgn = rev_sel ? fs : ts;
            m.ta = ta;
            m.fa = fa;
            m.fr = fr;
            m.ap = ap;
            if (ipk_v) m.cpk = {5'h0, ipk_s, ipk_m};
            if (vpk_v) m.vpk = {5'h0, vpk_s, vpk_m};
            if (reg_write && reg_addr == LP_OC_LEVEL_ADDR) m.oc = reg_wdata[7:0];
            if (reg_write && reg_addr == LP_CONFIG_ADDR) m.cfg = reg_wdata[7:0];
            if (reg_write && spi && reg_addr == PORT_SELECT_ADDR) m.sel = reg_wdata[0];
        end
    end

    // ------------------------------------------------------------
    // Comparison and verdict
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic give_verdict;
        if (failures == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // Outputs settle by the falling edge
    always @(negedge clock_i) begin
        if (!sys_rst_i) begin
            chk("rvalid", m.rv, reg_rvalid);
            if (m.rv) chk("rdata", m.rd, reg_rdata);
            chk("select", m.sel, sel_pin);
            chk("signs", m.sgn, signs);
            chk("oc_level", m.oc, oc_lvl);
            chk("config", m.cfg, cfg);
        end
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    task automatic read_all;
        foreach (tab[i]) host.op(1'b1, 1'b0, tab[i], 32'h0);
    endtask : read_all

    // Random traffic: back-to-back accesses with events underneath
    task automatic run(input int n);
        for (int i = 0; i < n; i++) begin
            e = $urandom;
            f = $urandom;
            g = $urandom;
            a = tab[g[4:2]];
            if (g[1:0] == 2'd0) a = RESERVED_LO_ADDR + 16'(g[24:16] % 9'd500);
            if (g[1:0] == 2'd1) a = 16'he503;
            host.op(e[0], e[1] & e[2], a, f);
            if (e[5:3] == 3'd0) ta <= ta ^ g[7:5];
            if (e[8:6] == 3'd0) fa <= fa ^ g[10:8];
            if (e[11:9] == 3'd0) fr <= fr ^ g[13:11];
            if (e[14:12] == 3'd0) ap <= ap ^ g[15:13];
            if (e[17:15] == 3'd0) ts <= f[2:0];
            if (e[20:18] == 3'd0) fs <= f[5:3];
            if (e[24:21] == 4'd0) rev_sel <= ~rev_sel;
            if (e[27:25] == 3'd0) lc_mode <= ~lc_mode;
            lc_done <= e[30:28] == 3'd0;
            spi <= g[31] | g[30];
            ipk_v <= e[31] & g[25];
            vpk_v <= g[26] & g[27];
            ipk_m <= f[23:0];
            vpk_m <= {f[11:0], f[31:20]};
            ipk_s <= f[26:24];
            vpk_s <= f[29:27];
        end
    endtask : run

    initial begin
        void'($urandom(32'hc0b0));
        repeat (8) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        read_all();
        run(600);
        host.op(1'b0, 1'b0, 16'h0, 32'h0);
        sys_rst_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        read_all();
        run(600);
        give_verdict();
    end

    // Hang guard, well past the expected 1233 cycles
    initial begin
        #(25 * 3000);
        failures++;
        give_verdict();
    end
endmodule : test_peak_detect_and_status_flags
`default_nettype wire
